// File: fnps_top.sv
// Purpose: frame counter, frame start sequencing and periodic threshold register
// Assumes: single clock, synchronous register port with one-cycle read data
// Notes: frame count rolls over at the top of its 14-bit field
`timescale 1ns/1ps
`default_nettype none
`include "fnps_cfg.svh"
module fnps_top #(
  parameter int W = `FNPS_FIELD_W
) (
  input  wire logic                   ref_clk_i,
  input  wire logic                   reset_i,
  input  wire fnps_pkg::fnps_reg_req_t reg_req_i,
  output logic [31:0]                 reg_rdata_o,
  input  wire logic                   countdown_reload_i,
  input  wire logic [W-1:0]           frame_time_left_i,
  input  wire logic                   bus_running_state_i,
  input  wire logic                   nonper_busy_i,
  input  wire logic                   sof_done_i,
  input  wire logic                   store_done_i,
  output logic                        sof_send_o,
  output logic                        comm_store_o,
  output logic [W-1:0]                comm_store_data_o,
  output logic                        ed_fetch_o,
  output logic                        frame_start_flag_o,
  output logic                        periodic_prio_o
);
  typedef struct packed {
    logic [W-1:0]        frame_count;
    logic [W-1:0]        threshold;
    logic                running;
    fnps_pkg::fnps_seq_t seq;
    logic                sof;
    logic                store;
    logic                fetch;
    logic                flag;
    logic [31:0]         rdata;
  } fnps_st_t;

  fnps_st_t st_r;
  fnps_st_t st_nxt;
  logic     enter_run;
  logic     prio;

  assign enter_run = bus_running_state_i && !st_r.running;

  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.sof   = 1'b0;
    st_nxt.store = 1'b0;
    st_nxt.fetch = 1'b0;
    st_nxt.flag  = 1'b0;
    st_nxt.rdata = 32'h0000_0000;
    st_nxt.running = bus_running_state_i;
    if (reg_req_i.wr && reg_req_i.addr == `FNPS_OFS_FRAME_COUNT)
    begin
      st_nxt.frame_count = reg_req_i.wdata[W-1:0];
    end
    if (reg_req_i.wr && reg_req_i.addr == `FNPS_OFS_PERIODIC)
    begin
      st_nxt.threshold = reg_req_i.wdata[W-1:0];
    end
    if (reg_req_i.rd)
    begin
      if (reg_req_i.addr == `FNPS_OFS_FRAME_COUNT)
      begin
        st_nxt.rdata = {{(32-W){1'b0}}, st_r.frame_count};
      end
      else if (reg_req_i.addr == `FNPS_OFS_PERIODIC)
      begin
        st_nxt.rdata = {{(32-W){1'b0}}, st_r.threshold};
      end
    end
    if (enter_run || (countdown_reload_i && st_r.running))
    begin
      st_nxt.frame_count = st_r.frame_count + 1'b1;
      st_nxt.seq = fnps_pkg::FNPS_SOF;
      st_nxt.sof = 1'b1;
    end
    else
    begin
      unique case (st_r.seq)
        fnps_pkg::FNPS_IDLE:
        begin
        end
        fnps_pkg::FNPS_SOF:
        begin
          if (sof_done_i)
          begin
            st_nxt.seq   = fnps_pkg::FNPS_WAIT_STORE;
            st_nxt.store = 1'b1;
          end
        end
        fnps_pkg::FNPS_STORE:
        begin
          st_nxt.seq = fnps_pkg::FNPS_WAIT_STORE;
        end
        fnps_pkg::FNPS_WAIT_STORE:
        begin
          if (store_done_i)
          begin
            st_nxt.seq   = fnps_pkg::FNPS_FETCH;
            st_nxt.flag  = 1'b1;
            st_nxt.fetch = 1'b1;
          end
        end
        fnps_pkg::FNPS_FETCH:
        begin
          st_nxt.seq = fnps_pkg::FNPS_IDLE;
        end
        default:
        begin
          st_nxt.seq = fnps_pkg::FNPS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      st_r             <= '0;
      st_r.frame_count <= `FNPS_FRAME_RST;
      st_r.threshold   <= `FNPS_PERIODIC_RST;
      st_r.seq         <= fnps_pkg::FNPS_IDLE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  fnps_thresh #(
    .W(W)
  ) u_thresh (
    .ref_clk_i         (ref_clk_i),
    .reset_i           (reset_i),
    .frame_boundary_i  (countdown_reload_i),
    .frame_time_left_i (frame_time_left_i),
    .threshold_i       (st_r.threshold),
    .nonper_busy_i     (nonper_busy_i),
    .periodic_prio_o   (prio)
  );

  // a flop is already inside the threshold module, so prio is a registered value
  assign periodic_prio_o    = prio;
  assign reg_rdata_o        = st_r.rdata;
  assign sof_send_o         = st_r.sof;
  assign comm_store_o       = st_r.store;
  assign comm_store_data_o  = st_r.frame_count;
  assign ed_fetch_o         = st_r.fetch;
  assign frame_start_flag_o = st_r.flag;

  AST_FC_STEP: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (countdown_reload_i && st_r.running && !reg_req_i.wr)
    |=> st_r.frame_count == $past(st_r.frame_count) + 14'h0001)
    else $error("frame count did not step on reload");
  AST_FC_WRAP: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (countdown_reload_i && st_r.running && st_r.frame_count == 14'h3FFF)
    |=> st_r.frame_count == 14'h0000)
    else $error("frame count did not wrap");
  AST_RUN_STEP: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (enter_run && !reg_req_i.wr) |=> st_r.frame_count == $past(st_r.frame_count) + 14'h0001)
    else $error("no step entering running state");
  AST_STORE_AFTER_SOF: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    comm_store_o |-> $past(st_r.seq) == fnps_pkg::FNPS_SOF)
    else $error("store before sof");
  AST_FETCH_AFTER_STORE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ed_fetch_o |-> $past(st_r.seq) == fnps_pkg::FNPS_WAIT_STORE && $past(store_done_i))
    else $error("fetch before store finished");
  AST_FLAG_WITH_FETCH: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    frame_start_flag_o == ed_fetch_o)
    else $error("frame start flag out of step");
  AST_THR_WRITE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (reg_req_i.wr && reg_req_i.addr == `FNPS_OFS_PERIODIC)
    |=> st_r.threshold == $past(reg_req_i.wdata[13:0]))
    else $error("threshold write lost");
  AST_RDATA_HIGH: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    reg_rdata_o[31:14] == 18'h00000)
    else $error("reserved bits read nonzero");
endmodule
`default_nettype wire

// File: fnps_cfg.svh
// Purpose: offsets, field width, field position and reset values of the frame number block
// Assumes: 32-bit register access at word offsets
// Notes: included by bare name
`ifndef FNPS_CFG_SVH
`define FNPS_CFG_SVH
`define FNPS_OFS_FRAME_COUNT   8'h3C
`define FNPS_OFS_PERIODIC      8'h40
`define FNPS_FIELD_W           14
`define FNPS_PERIODIC_RST      14'h0000
`define FNPS_FRAME_RST         14'h0000
`define FNPS_SF_BIT            2
`endif

// File: fnps_pkg.sv
// Purpose: types of the frame number block
// Assumes: fnps_cfg.svh constants
// Notes: none
package fnps_pkg;
  typedef enum logic [2:0] {
    FNPS_IDLE,
    FNPS_SOF,
    FNPS_STORE,
    FNPS_WAIT_STORE,
    FNPS_FETCH
  } fnps_seq_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } fnps_reg_req_t;
endpackage

// File: fnps_thresh.sv
// Purpose: periodic priority decision from countdown and threshold
// Assumes: countdown updates once per bit time
// Notes: priority waits for the running control or bulk transaction to end
`timescale 1ns/1ps
`default_nettype none
`include "fnps_cfg.svh"
module fnps_thresh #(
  parameter int W = `FNPS_FIELD_W
) (
  input  wire logic         ref_clk_i,
  input  wire logic         reset_i,
  input  wire logic         frame_boundary_i,
  input  wire logic [W-1:0] frame_time_left_i,
  input  wire logic [W-1:0] threshold_i,
  input  wire logic         nonper_busy_i,
  output logic              periodic_prio_o
);
  typedef struct packed {
    logic reached;
    logic prio;
  } fnps_th_st_t;

  fnps_th_st_t st_r;
  fnps_th_st_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (frame_boundary_i)
    begin
      st_nxt.reached = 1'b0;
      st_nxt.prio    = 1'b0;
    end
    else
    begin
      if (frame_time_left_i <= threshold_i)
      begin
        st_nxt.reached = 1'b1;
      end
      if (st_r.reached && !nonper_busy_i)
      begin
        st_nxt.prio = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign periodic_prio_o = st_r.prio;

  AST_PRIO_WAITS: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $rose(st_r.prio) |-> $past(st_r.reached) && !$past(nonper_busy_i))
    else $error("priority raised during a nonperiodic transaction");
  AST_REACH_CMP: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (!frame_boundary_i && frame_time_left_i <= threshold_i) |=> st_r.reached)
    else $error("threshold crossing missed");
endmodule
`default_nettype wire

// File: fnps_engine_model.sv
// Purpose: list engine stand-in that answers frame start and store requests
// Assumes: requests arrive as one-cycle pulses
// Notes: fixed latency keeps each answer late enough to expose order slips
`timescale 1ns/1ps
`default_nettype none
module fnps_engine_model #(
  parameter int DLY = 3
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic sof_send_i,
  input  wire logic comm_store_i,
  output logic      sof_done_o,
  output logic      store_done_o
);
  logic [DLY-1:0] sof_q;
  logic [DLY-1:0] st_q;
  // answers only after the request, never ahead of it
  always_ff @(posedge clk_i or posedge reset_i)
    if (reset_i)
    begin
      sof_q <= '0;
      st_q  <= '0;
    end
    else
    begin
      sof_q <= {sof_q[DLY-2:0], sof_send_i};
      st_q  <= {st_q[DLY-2:0], comm_store_i};
    end
  assign sof_done_o   = sof_q[DLY-1];
  assign store_done_o = st_q[DLY-1];
endmodule
`default_nettype wire

// File: fnps_tb.sv
// Purpose: self-checking bench for the frame number and periodic start block
// Assumes: inputs change by non-blocking assignment at the rising edge
// Notes: each wait is bounded and a timeout ends the run
`timescale 1ns/1ps
`default_nettype none
module frame_number_periodic_start_test;
  logic                    clk = 1'b0;
  logic                    rst = 1'b1;
  fnps_pkg::fnps_reg_req_t req = '0;
  logic                    rld = 1'b0;
  logic                    run = 1'b0;
  logic                    busy = 1'b1;
  logic [13:0]             left = 14'h3FFF;
  logic [31:0]             rdata;
  logic [13:0]             sdata;
  logic                    sof, sdone, st, stdone, fetch, flag, prio;
  logic [4:0]              obs;
  int                      mismatches = 0;
  int                      checks_done = 0;
  assign obs = {prio, flag, fetch, st, sof};
  initial forever #2.5 clk = ~clk;
  fnps_top DUT (.ref_clk_i(clk), .reset_i(rst), .reg_req_i(req), .reg_rdata_o(rdata),
    .countdown_reload_i(rld), .frame_time_left_i(left), .bus_running_state_i(run),
    .nonper_busy_i(busy), .sof_done_i(sdone), .store_done_i(stdone), .sof_send_o(sof),
    .comm_store_o(st), .comm_store_data_o(sdata), .ed_fetch_o(fetch),
    .frame_start_flag_o(flag), .periodic_prio_o(prio));
  fnps_engine_model #(.DLY(3)) eng (.clk_i(clk), .reset_i(rst), .sof_send_i(sof),
    .comm_store_i(st), .sof_done_o(sdone), .store_done_o(stdone));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clk);
    req <= '0;
    #1;
    chk(rdata, exp, "register read");
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '0;
  endtask
  // first look lands 1 ns after the caller's edge so a one-cycle pulse is not missed
  task automatic wait_bit(input int b);
    int n;
    n = 0;
    #1;
    while (obs[b] !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (obs[b] !== 1'b1)
    begin
      mismatches++;
      $display("[ERR] t=%0t wait timed out on %0d", $time, b);
      finish_test();
    end
  endtask
  task automatic pulse_rld();
    @(posedge clk);
    rld <= 1'b1;
    @(posedge clk);
    rld <= 1'b0;
  endtask
  task automatic frame(input logic [13:0] exp);
    wait_bit(0);
    chk(st, 0, "store before frame start");
    wait_bit(1);
    chk(sdata, exp, "stored count");
    chk(fetch, 0, "fetch before store");
    wait_bit(2);
    chk(flag, 1, "frame start flag");
  endtask
  task automatic t_regs();
    reg_rd(8'h3C, 32'h0);
    reg_rd(8'h40, 32'h0);
    reg_rd(8'h44, 32'h0);
    reg_wr(8'h40, 32'h0000_3E67);
    reg_rd(8'h40, 32'h0000_3E67);
    $display("test regs done");
  endtask
  task automatic t_frames();
    @(posedge clk);
    run <= 1'b1;
    frame(14'h0001);
    pulse_rld();
    frame(14'h0002);
    reg_wr(8'h3C, 32'h0000_3FFF);
    reg_rd(8'h3C, 32'h0000_3FFF);
    pulse_rld();
    frame(14'h0000);
    $display("test frames done");
  endtask
  task automatic t_prio();
    @(posedge clk);
    left <= 14'h3E68;
    repeat (4) @(posedge clk);
    #1;
    chk(prio, 0, "prio above threshold");
    @(posedge clk);
    left <= 14'h3E67;
    repeat (4) @(posedge clk);
    #1;
    chk(prio, 0, "prio while busy");
    @(posedge clk);
    busy <= 1'b0;
    wait_bit(4);
    chk(prio, 1, "prio after busy ends");
    pulse_rld();
    #1;
    chk(prio, 0, "prio cleared by reload");
    $display("test prio done");
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_frames();
    t_prio();
    finish_test();
  end
endmodule
`default_nettype wire
